// [rtl/bbx_alu.sv]
`include "bbx_params.svh"

module bbx_alu #(
	parameter int DATA_W = `BBX_DATA_W
) (
	bbx_alu_if.alu alu
);
	// ----------------------------------------
	// Adder with nibble carry
	// ----------------------------------------
	logic [DATA_W-1:0] addend;
	logic [DATA_W:0] sum;
	logic [`BBX_NIBBLE_W:0] low_sum;
	logic [DATA_W-1:0] bit_mask;
	logic tested;

	always_comb begin
		addend = (alu.op == bbx_pkg::op_add_literal_to_acc) ? alu.literal : alu.operand;
		sum = {1'b0, alu.acc} + {1'b0, addend};
		low_sum = {1'b0, alu.acc[`BBX_NIBBLE_W-1:0]} + {1'b0, addend[`BBX_NIBBLE_W-1:0]};
		bit_mask = DATA_W'(1) << alu.bit_sel;
		tested = |(alu.operand & bit_mask);
	end

	// ----------------------------------------
	// Result select
	// ----------------------------------------
	always_comb begin
		alu.result = alu.operand;
		alu.skip = 1'b0;
		unique case (alu.op)
			bbx_pkg::op_add_literal_to_acc,
			bbx_pkg::op_add_acc_and_file: begin
				alu.result = sum[DATA_W-1:0];
			end
			bbx_pkg::op_and_literal_with_acc: begin
				alu.result = alu.acc & alu.literal;
			end
			bbx_pkg::op_and_acc_with_file: begin
				alu.result = alu.acc & alu.operand;
			end
			bbx_pkg::op_bit_clear_file: begin
				alu.result = alu.operand & ~bit_mask;
			end
			bbx_pkg::op_bit_set_file: begin
				alu.result = alu.operand | bit_mask;
			end
			bbx_pkg::op_test_skip_if_clear: begin
				alu.skip = ~tested;
			end
			bbx_pkg::op_test_skip_if_set: begin
				alu.skip = tested;
			end
			bbx_pkg::op_no_operation: begin
				alu.result = alu.operand;
			end
			default: begin
				alu.result = alu.operand;
			end
		endcase
	end

	// ----------------------------------------
	// Flags
	// ----------------------------------------
	always_comb begin
		alu.carry = sum[DATA_W];
		alu.digit_carry_flag = low_sum[`BBX_NIBBLE_W];
		alu.zero = (alu.result == '0);
	end
endmodule

// [rtl/bbx_alu_if.sv]
`include "bbx_params.svh"

interface bbx_alu_if #(
	parameter int DATA_W = `BBX_DATA_W
);
	bbx_pkg::bbx_op_t op;
	logic [DATA_W-1:0] acc;
	logic [DATA_W-1:0] operand;
	logic [DATA_W-1:0] literal;
	logic [`BBX_BIT_W-1:0] bit_sel;
	logic [DATA_W-1:0] result;
	logic carry;
	logic digit_carry_flag;
	logic zero;
	logic skip;

	modport core (
		output op,
		output acc,
		output operand,
		output literal,
		output bit_sel,
		input result,
		input carry,
		input digit_carry_flag,
		input zero,
		input skip
	);

	modport alu (
		input op,
		input acc,
		input operand,
		input literal,
		input bit_sel,
		output result,
		output carry,
		output digit_carry_flag,
		output zero,
		output skip
	);
endinterface

// [rtl/bbx_exec.sv]
// What this block does
// - Literal add: accumulator plus 8-bit literal into accumulator, sets all three flags.
// - File add: accumulator plus file register 0..127, sets carry, digit carry, zero.
// - Destination bit 0 writes accumulator, 1 writes back the file register.
// - Literal AND: accumulator AND literal into accumulator, only Z changes.
// - File AND: accumulator AND file register to destination, only Z changes.
// - Bit clear: chosen bit 0..7 of file register forced low, no flags.
// - Bit set: chosen bit of file register forced high, no flags.
// - Skip-if-clear: bit low discards next instruction as a no-op cycle.
// - Skip-if-set: bit high discards next instruction as a no-op cycle.
// - Read-modify-write on a port register uses pin levels as operand.
// - A true test costs two cycles; the second runs as a no-op.
//
// Added by the designer: the APB slave port and the register addresses.
`include "bbx_params.svh"

module bbx_exec #(
	parameter int DATA_W = `BBX_DATA_W,
	parameter int FADDR_W = `BBX_FADDR_W,
	parameter int CNT_W = `BBX_CNT_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire bbx_pkg::bbx_op_t op_code,
	input wire logic [FADDR_W-1:0] op_file_addr,
	input wire logic [DATA_W-1:0] op_literal,
	input wire logic [`BBX_BIT_W-1:0] op_bit,
	input wire logic op_dest,
	output logic ex_retire,
	output logic ex_discard,
	output logic ex_skip_pending,
	output logic [FADDR_W-1:0] rf_rd_addr,
	input wire logic [DATA_W-1:0] rf_rd_data,
	input wire logic rf_rd_is_port,
	input wire logic [DATA_W-1:0] port_pins,
	output logic rf_wr_en,
	output logic [FADDR_W-1:0] rf_wr_addr,
	output logic [DATA_W-1:0] rf_wr_data,
	output logic [DATA_W-1:0] acc_out,
	output logic [`BBX_FLAGS_W-1:0] flags_out,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`BBX_APB_AW-1:0] paddr,
	input wire logic [`BBX_APB_DW-1:0] pwdata,
	output logic [`BBX_APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	bbx_alu_if #(.DATA_W(DATA_W)) alu_bus ();

	bbx_pkg::bbx_state_t state_q;
	logic [DATA_W-1:0] acc_q;
	logic [`BBX_FLAGS_W-1:0] flags_q;
	logic [DATA_W-1:0] pins_level;
	logic [DATA_W-1:0] operand;
	logic do_exec;
	logic do_discard;
	logic is_add;
	logic is_and;
	logic is_file_arith;
	logic is_bit_op;
	logic wr_acc;
	logic wr_file;
	logic fwd_hit;
	logic wb_en_q;
	logic [FADDR_W-1:0] wb_addr_q;
	logic [DATA_W-1:0] wb_data_q;
	logic retire_q;
	logic discard_q;
	logic [CNT_W-1:0] exec_cnt_q;
	logic [CNT_W-1:0] discard_cnt_q;
	logic apb_setup;
	logic apb_access;
	logic apb_write;
	logic apb_hit;
	logic [`BBX_APB_DW-1:0] rd_mux;
	logic [`BBX_APB_DW-1:0] prdata_q;

	// ----------------------------------------
	// Pin levels for port registers
	// ----------------------------------------
	bbx_pin_sync #(.WIDTH(DATA_W)) u_pin_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pins_async(port_pins),
		.pins_level(pins_level)
	);

	// ----------------------------------------
	// Issue and discard
	// ----------------------------------------
	always_comb begin
		do_exec = op_valid && (state_q == bbx_pkg::st_run);
		do_discard = op_valid && (state_q == bbx_pkg::st_skip);
	end

	// ----------------------------------------
	// Operation classes
	// ----------------------------------------
	always_comb begin
		is_add = (op_code == bbx_pkg::op_add_literal_to_acc)
			|| (op_code == bbx_pkg::op_add_acc_and_file);
		is_and = (op_code == bbx_pkg::op_and_literal_with_acc)
			|| (op_code == bbx_pkg::op_and_acc_with_file);
		is_file_arith = (op_code == bbx_pkg::op_add_acc_and_file)
			|| (op_code == bbx_pkg::op_and_acc_with_file);
		is_bit_op = (op_code == bbx_pkg::op_bit_clear_file)
			|| (op_code == bbx_pkg::op_bit_set_file);
	end

	always_comb begin
		wr_acc = do_exec && ((op_code == bbx_pkg::op_add_literal_to_acc)
			|| (op_code == bbx_pkg::op_and_literal_with_acc)
			|| (is_file_arith && (op_dest == `BBX_DEST_ACC)));
		wr_file = do_exec && (is_bit_op
			|| (is_file_arith && (op_dest == `BBX_DEST_FILE)));
	end

	// ----------------------------------------
	// Operand fetch
	// ----------------------------------------
	assign rf_rd_addr = op_file_addr;

	always_comb begin
		fwd_hit = wb_en_q && (wb_addr_q == op_file_addr);
		if (rf_rd_is_port) begin
			operand = pins_level;
		end else if (fwd_hit) begin
			operand = wb_data_q;
		end else begin
			operand = rf_rd_data;
		end
	end

	// ----------------------------------------
	// Arithmetic unit
	// ----------------------------------------
	always_comb begin
		alu_bus.op = do_exec ? op_code : bbx_pkg::op_no_operation;
		alu_bus.acc = acc_q;
		alu_bus.operand = operand;
		alu_bus.literal = op_literal;
		alu_bus.bit_sel = op_bit;
	end

	bbx_alu #(.DATA_W(DATA_W)) u_alu (
		.alu(alu_bus)
	);

	// ----------------------------------------
	// Skip sequencing
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= bbx_pkg::st_run;
		end else if (do_exec && alu_bus.skip) begin
			state_q <= bbx_pkg::st_skip;
		end else if (do_discard) begin
			state_q <= bbx_pkg::st_run;
		end
	end

	// ----------------------------------------
	// Accumulator
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			acc_q <= `BBX_ACC_RST;
		end else if (wr_acc) begin
			acc_q <= alu_bus.result;
		end else if (apb_write && (paddr == `BBX_REG_ACC)) begin
			acc_q <= pwdata[DATA_W-1:0];
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flags_q <= `BBX_FLAGS_RST;
		end else if (do_exec && is_add) begin
			flags_q[`BBX_FLAG_C] <= alu_bus.carry;
			flags_q[`BBX_FLAG_DIG] <= alu_bus.digit_carry_flag;
			flags_q[`BBX_FLAG_Z] <= alu_bus.zero;
		end else if (do_exec && is_and) begin
			flags_q[`BBX_FLAG_Z] <= alu_bus.zero;
		end else if (apb_write && (paddr == `BBX_REG_FLAGS)) begin
			flags_q <= pwdata[`BBX_FLAGS_W-1:0];
		end
	end

	// ----------------------------------------
	// File write-back
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wb_en_q <= 1'b0;
		end else begin
			wb_en_q <= wr_file;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wb_addr_q <= '0;
			wb_data_q <= '0;
		end else if (wr_file) begin
			wb_addr_q <= op_file_addr;
			wb_data_q <= alu_bus.result;
		end
	end

	// ----------------------------------------
	// Completion pulses
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			retire_q <= 1'b0;
			discard_q <= 1'b0;
		end else begin
			retire_q <= do_exec;
			discard_q <= do_discard;
		end
	end

	// ----------------------------------------
	// Event counters
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			exec_cnt_q <= '0;
		end else if (do_exec) begin
			exec_cnt_q <= exec_cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			discard_cnt_q <= '0;
		end else if (do_discard) begin
			discard_cnt_q <= discard_cnt_q + CNT_W'(1);
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	always_comb begin
		apb_setup = psel && !penable;
		apb_access = psel && penable;
		apb_write = apb_access && pwrite;
		apb_hit = (paddr == `BBX_REG_ACC) || (paddr == `BBX_REG_FLAGS)
			|| (paddr == `BBX_REG_STAT) || (paddr == `BBX_REG_COUNT);
	end

	always_comb begin
		rd_mux = '0;
		unique case (paddr)
			`BBX_REG_ACC: begin
				rd_mux[DATA_W-1:0] = acc_q;
			end
			`BBX_REG_FLAGS: begin
				rd_mux[`BBX_FLAGS_W-1:0] = flags_q;
			end
			`BBX_REG_STAT: begin
				rd_mux[`BBX_STAT_SKIP] = (state_q == bbx_pkg::st_skip);
				rd_mux[`BBX_STAT_WB] = wb_en_q;
			end
			`BBX_REG_COUNT: begin
				rd_mux = `BBX_APB_DW'({discard_cnt_q, exec_cnt_q});
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prdata_q <= '0;
		end else if (apb_setup) begin
			prdata_q <= pwrite ? '0 : rd_mux;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pready = 1'b1;
	assign pslverr = apb_access && !apb_hit;
	assign prdata = prdata_q;
	assign rf_wr_en = wb_en_q;
	assign rf_wr_addr = wb_addr_q;
	assign rf_wr_data = wb_data_q;
	assign acc_out = acc_q;
	assign flags_out = flags_q;
	assign ex_retire = retire_q;
	assign ex_discard = discard_q;
	assign ex_skip_pending = (state_q == bbx_pkg::st_skip);
endmodule

// [rtl/bbx_params.svh]
`ifndef BBX_PARAMS_SVH
`define BBX_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define BBX_DATA_W 8
`define BBX_FADDR_W 7
`define BBX_BIT_W 3
`define BBX_NIBBLE_W 4
`define BBX_APB_AW 8
`define BBX_APB_DW 32
`define BBX_CNT_W 16
`define BBX_SYNC_STAGES 3

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BBX_REG_ACC 8'h00
`define BBX_REG_FLAGS 8'h04
`define BBX_REG_STAT 8'h08
`define BBX_REG_COUNT 8'h0C

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define BBX_FLAG_C 0
`define BBX_FLAG_DIG 1
`define BBX_FLAG_Z 2
`define BBX_FLAGS_W 3
`define BBX_STAT_SKIP 0
`define BBX_STAT_WB 1
`define BBX_ACC_RST 8'h00
`define BBX_FLAGS_RST 3'h0
`define BBX_DEST_ACC 1'b0
`define BBX_DEST_FILE 1'b1

`endif

// [rtl/bbx_pin_sync.sv]
`include "bbx_params.svh"

module bbx_pin_sync #(
	parameter int WIDTH = `BBX_DATA_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pins_async,
	output logic [WIDTH-1:0] pins_level
);
	// ----------------------------------------
	// Three stages, change taken when last two agree
	// ----------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic [`BBX_SYNC_STAGES-1:0] stage_q;
		logic level_q;

		always_ff @(posedge sys_clk) begin
			if (!rst_n) begin
				stage_q <= '0;
			end else begin
				stage_q <= {stage_q[`BBX_SYNC_STAGES-2:0], pins_async[i]};
			end
		end

		always_ff @(posedge sys_clk) begin
			if (!rst_n) begin
				level_q <= 1'b0;
			end else if (stage_q[`BBX_SYNC_STAGES-2] == stage_q[`BBX_SYNC_STAGES-1]) begin
				level_q <= stage_q[`BBX_SYNC_STAGES-1];
			end
		end

		assign pins_level[i] = level_q;
	end
endmodule

// [rtl/bbx_pkg.sv]
package bbx_pkg;

	// ----------------------------------------
	// Operations and states
	// ----------------------------------------
	typedef enum logic [3:0] {
		op_no_operation,
		op_add_literal_to_acc,
		op_add_acc_and_file,
		op_and_literal_with_acc,
		op_and_acc_with_file,
		op_bit_clear_file,
		op_bit_set_file,
		op_test_skip_if_clear,
		op_test_skip_if_set
	} bbx_op_t;

	typedef enum logic {
		st_run,
		st_skip
	} bbx_state_t;

endpackage

// [test/bbx_chk.sv]
`include "bbx_params.svh"

module bbx_chk (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire bbx_pkg::bbx_op_t op_code,
	input wire logic [`BBX_DATA_W-1:0] op_literal,
	input wire logic [`BBX_BIT_W-1:0] op_bit,
	input wire logic ex_retire,
	input wire logic ex_discard,
	input wire logic ex_skip_pending,
	input wire logic [`BBX_DATA_W-1:0] rf_rd_data,
	input wire logic rf_rd_is_port,
	input wire logic rf_wr_en,
	input wire logic [`BBX_DATA_W-1:0] acc_out,
	input wire logic [`BBX_FLAGS_W-1:0] flags_out,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Helpers
	// ----
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic go, apbw, cy, nib, zs, tb, clean;
	logic [7:0] sum;
	assign go = op_valid && !ex_skip_pending;
	assign apbw = psel && penable && pwrite;
	assign {cy, sum} = acc_out + op_literal;
	assign nib = ({1'b0, acc_out[3:0]} + op_literal[3:0]) > 5'hF;
	assign zs = (sum == 8'h00);
	assign tb = rf_rd_data[op_bit];
	assign clean = !rf_rd_is_port && !rf_wr_en;
	// ----
	// Properties
	// ----
	a_exec_retire:
	assert property (go |=> ex_retire && !ex_discard) else $error("retire missing");
	a_skip_discard:
	assert property (op_valid && ex_skip_pending |=> ex_discard && !ex_retire && !rf_wr_en
		&& !ex_skip_pending) else $error("discard wrong");
	a_lit_add:
	assert property (go && op_code == bbx_pkg::op_add_literal_to_acc |=> acc_out == $past(sum)
		&& flags_out == {$past(zs), $past(nib), $past(cy)}) else $error("literal add wrong");
	a_and_keeps:
	assert property (go && !apbw && (op_code == bbx_pkg::op_and_literal_with_acc
		|| op_code == bbx_pkg::op_and_acc_with_file) |=> $stable(flags_out[1:0]))
		else $error("and changed carry");
	a_bit_quiet:
	assert property (go && !apbw && op_code inside {bbx_pkg::op_bit_clear_file,
		bbx_pkg::op_bit_set_file} |=> $stable(flags_out) && $stable(acc_out))
		else $error("bit op changed state");
	a_test_nowr:
	assert property (go && op_code inside {bbx_pkg::op_test_skip_if_clear,
		bbx_pkg::op_test_skip_if_set} |=> !rf_wr_en) else $error("test wrote file");
	a_skip_clear:
	assert property (go && clean && op_code == bbx_pkg::op_test_skip_if_clear
		|=> ex_skip_pending == !$past(tb)) else $error("skip clear wrong");
	a_skip_set:
	assert property (go && clean && op_code == bbx_pkg::op_test_skip_if_set
		|=> ex_skip_pending == $past(tb)) else $error("skip set wrong");
endmodule

bind bbx_exec bbx_chk u_chk (.sys_clk, .rst_n, .op_valid, .op_code, .op_literal, .op_bit,
	.ex_retire, .ex_discard, .ex_skip_pending, .rf_rd_data, .rf_rd_is_port, .rf_wr_en,
	.acc_out, .flags_out, .psel, .penable, .pwrite);

// [test/bbx_rf_model.sv]
`include "bbx_params.svh"

module bbx_rf_model #(
	parameter logic [`BBX_FADDR_W-1:0] PORT_ADDR = 7'h05
) (
	input wire logic sys_clk,
	input wire logic [`BBX_FADDR_W-1:0] rf_rd_addr,
	output logic [`BBX_DATA_W-1:0] rf_rd_data,
	output logic rf_rd_is_port,
	input wire logic rf_wr_en,
	input wire logic [`BBX_FADDR_W-1:0] rf_wr_addr,
	input wire logic [`BBX_DATA_W-1:0] rf_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// File storage
	// ----
	logic [`BBX_DATA_W-1:0] mem [0:127];
	assign rf_rd_data = mem[rf_rd_addr];
	assign rf_rd_is_port = (rf_rd_addr == PORT_ADDR);
	always @(posedge sys_clk) begin
		if (rf_wr_en) begin
			mem[rf_wr_addr] <= rf_wr_data;
		end
	end
endmodule

// [test/byte_bit_op_execute_test.sv]
`include "bbx_params.svh"

module byte_bit_op_execute_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] PORT = 7'h05;
	logic sys_clk, rst_n, op_valid, op_dest, rf_rd_is_port, rf_wr_en, psel, penable, pwrite;
	logic pready, pslverr, ex_retire, ex_discard, ex_skip_pending, skip, er;
	bbx_pkg::bbx_op_t op_code;
	logic [6:0] op_file_addr, rf_rd_addr, rf_wr_addr;
	logic [7:0] op_literal, rf_rd_data, port_pins, rf_wr_data, acc_out, paddr, acc;
	logic [2:0] op_bit, flags_out, fl;
	logic [31:0] pwdata, prdata, rd;
	int fail_count, n_compared, cyc, n_exec, n_disc;
	integer seed = 32'h63375222;

	bbx_exec DUT (.sys_clk, .rst_n, .op_valid, .op_code, .op_file_addr, .op_literal, .op_bit,
		.op_dest, .ex_retire, .ex_discard, .ex_skip_pending, .rf_rd_addr, .rf_rd_data,
		.rf_rd_is_port, .port_pins, .rf_wr_en, .rf_wr_addr, .rf_wr_data, .acc_out, .flags_out,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	bbx_rf_model #(.PORT_ADDR(PORT)) rf (.sys_clk, .rf_rd_addr, .rf_rd_data, .rf_rd_is_port,
		.rf_wr_en, .rf_wr_addr, .rf_wr_data);

	initial begin
		sys_clk = 0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			give_verdict;
		end
	end

	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task check(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			$display("mismatch %s exp %h seen %h", nm, e, s);
			fail_count++;
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// ----
	// Expected result: skip, flags, value
	// ----
	function automatic logic [11:0] calc(bbx_pkg::bbx_op_t op, logic [7:0] a, f, k,
		logic [2:0] b, logic [2:0] fo);
		logic [8:0] s;
		logic [7:0] x;
		x = (op inside {bbx_pkg::op_add_literal_to_acc, bbx_pkg::op_and_literal_with_acc}) ? k : f;
		s = a + x;
		case (op)
			bbx_pkg::op_add_literal_to_acc, bbx_pkg::op_add_acc_and_file:
				return {1'b0, s[7:0] == 8'h00, ({1'b0, a[3:0]} + x[3:0]) > 5'hF, s[8], s[7:0]};
			bbx_pkg::op_and_literal_with_acc, bbx_pkg::op_and_acc_with_file:
				return {1'b0, (a & x) == 8'h00, fo[1:0], a & x};
			bbx_pkg::op_bit_clear_file: return {1'b0, fo, f & ~(8'h01 << b)};
			bbx_pkg::op_bit_set_file: return {1'b0, fo, f | (8'h01 << b)};
			bbx_pkg::op_test_skip_if_clear: return {!f[b], fo, f};
			bbx_pkg::op_test_skip_if_set: return {f[b], fo, f};
			default: return {1'b0, fo, a};
		endcase
	endfunction

	task do_op(bbx_pkg::bbx_op_t op, logic [6:0] a, logic [7:0] k, logic [2:0] b, logic d);
		logic [11:0] r;
		logic [7:0] f;
		logic wide;
		f = (a == PORT) ? port_pins : rf.mem[a];
		r = calc(op, acc, f, k, b, fl);
		wide = op inside {bbx_pkg::op_add_acc_and_file, bbx_pkg::op_and_acc_with_file};
		@(posedge sys_clk);
		op_valid <= 1;
		op_code <= op;
		op_file_addr <= a;
		op_literal <= k;
		op_bit <= b;
		op_dest <= d;
		@(posedge sys_clk);
		op_valid <= 0;
		#1;
		check("retire", ex_retire, !skip);
		check("discard", ex_discard, skip);
		if (skip) n_disc++;
		else n_exec++;
		if (!skip) begin
			fl = r[10:8];
			if (wide && !d || op inside {bbx_pkg::op_add_literal_to_acc,
				bbx_pkg::op_and_literal_with_acc}) acc = r[7:0];
			else f = r[7:0];
		end
		skip = !skip && r[11];
		check("acc", acc_out, acc);
		check("flags", flags_out, fl);
		check("skip", ex_skip_pending, skip);
		@(posedge sys_clk);
		#1;
		if (a != PORT) check("file", rf.mem[a], f);
	endtask

	initial begin
		rst_n = 0;
		op_valid = 0;
		op_code = bbx_pkg::op_no_operation;
		{op_file_addr, op_literal, op_bit, op_dest} = '0;
		port_pins = 8'h5A;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{fail_count, n_compared, cyc, n_exec, n_disc} = '0;
		{acc, fl, skip} = '0;
		for (int i = 0; i < 128; i++) rf.mem[i] = 8'($random(seed));
		repeat (5) @(posedge sys_clk);
		rst_n <= 1;
		apb(0, `BBX_REG_FLAGS, 0);
		check("flags reset", rd, 0);
		apb(1, `BBX_REG_FLAGS, 32'h00000005);
		fl = 3'h5;
		apb(0, `BBX_REG_FLAGS, 0);
		check("flags write", rd, fl);
		apb(1, `BBX_REG_ACC, 32'h000000C3);
		acc = 8'hC3;
		apb(0, `BBX_REG_ACC, 0);
		check("acc read", rd, acc);
		apb(0, 8'h10, 0);
		check("unmapped err", er, 1);
		check("unmapped data", rd, 0);
		$display("apb test done");
		do_op(bbx_pkg::op_bit_set_file, 7'h7F, 0, 3'h7, 0);
		do_op(bbx_pkg::op_test_skip_if_set, 7'h7F, 0, 3'h7, 0);
		do_op(bbx_pkg::op_add_literal_to_acc, 0, 8'hFF, 0, 0);
		do_op(bbx_pkg::op_bit_clear_file, 7'h7F, 0, 3'h7, 0);
		do_op(bbx_pkg::op_test_skip_if_clear, 7'h7F, 0, 3'h7, 0);
		do_op(bbx_pkg::op_add_acc_and_file, PORT, 0, 0, 0);
		do_op(bbx_pkg::op_add_acc_and_file, PORT, 0, 0, 0);
		do_op(bbx_pkg::op_add_literal_to_acc, 0, 8'hFF, 0, 0);
		@(posedge sys_clk);
		port_pins <= 8'hA5;
		repeat (4) @(posedge sys_clk);
		do_op(bbx_pkg::op_and_acc_with_file, PORT, 0, 0, 0);
		do_op(bbx_pkg::op_bit_clear_file, 7'h7E, 0, 3'h2, 0);
		@(posedge sys_clk);
		op_valid <= 1;
		op_code <= bbx_pkg::op_bit_set_file;
		op_file_addr <= 7'h7E;
		op_bit <= 3'h2;
		op_dest <= 0;
		@(posedge sys_clk);
		op_code <= bbx_pkg::op_test_skip_if_set;
		@(posedge sys_clk);
		op_valid <= 0;
		#1;
		check("fwd retire", ex_retire, 1);
		check("fwd skip", ex_skip_pending, 1);
		n_exec += 2;
		skip = 1;
		apb(0, `BBX_REG_STAT, 0);
		check("stat skip", rd, 32'h00000001);
		$display("corner test done");
		repeat (300) do_op(bbx_pkg::bbx_op_t'(4'(1 + $unsigned($random(seed)) % 8)),
			7'(16 + $unsigned($random(seed)) % 112), 8'($random(seed)), 3'($random(seed)),
			1'($random(seed)));
		$display("random test done");
		apb(0, `BBX_REG_COUNT, 0);
		check("count", rd, {16'(n_disc), 16'(n_exec)});
		give_verdict;
	end
endmodule
